// ===== hw/mwic_master.sv
/*
 host end of the margin/watchdog command port: bus master that sends START
 with the slave address and write bit, command bytes, and STOP.
 assumes the user issues one request at a time while req_ready is high.
*/
`timescale 1ns/10ps
`include "mwic_params.svh"
module mwic_master
	import mwic_pkg::*;
#(
	parameter int QTR_CYC = `MWIC_SCL_QTR_CYC
) (
	// clock, reset, enable
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	input  wire logic       ce,
	// serial bus
	mwic_if.host            bus,
	// user requests
	input  wire logic [6:0] target_addr,
	input  wire logic       req_valid,
	input  wire logic [1:0] req_kind,
	input  wire logic [7:0] req_byte,
	output logic            req_ready,
	output logic            done,
	output logic            nack
);

	// ==========================================================
	// sda read-back synchroniser
	logic            sda_a;
	logic            sda_s;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sda_a <= 1'b1;
			sda_s <= 1'b1;
		end else if (ce) begin
			sda_a <= bus.sda;
			sda_s <= sda_a;
		end
	end

	// ==========================================================
	// sequencer: four quarter-period steps per bit; no clock stretching
	mwic_host_state_t state;
	logic [15:0]     qcnt;
	logic [1:0]      step;
	logic [3:0]      bitn;
	logic [8:0]      tx;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state        <= M_IDLE;
			qcnt         <= 16'h0000;
			step         <= 2'h0;
			bitn         <= 4'h0;
			tx           <= 9'h1ff;
			req_ready    <= 1'b1;
			done         <= 1'b0;
			nack         <= 1'b0;
			bus.m_scl_oe <= 1'b0;
			bus.m_sda_oe <= 1'b0;
		end else if (ce) begin
			done <= 1'b0;
			if (state == M_IDLE) begin
				qcnt <= 16'h0000;
				step <= 2'h0;
				bitn <= 4'h0;
				if (req_valid) begin
					req_ready <= 1'b0;
					case (req_kind)
						K_START: begin
							state <= M_START;
							// write direction only
							tx    <= {target_addr, `MWIC_RW_WRITE, 1'b1};
						end
						K_BYTE: begin
							state <= M_BITS;
							tx    <= {req_byte, 1'b1};
						end
						default: begin
							state <= M_STOP;
						end
					endcase
				end
			end else if (qcnt != 16'(QTR_CYC - 1)) begin
				qcnt <= qcnt + 16'h0001;
			end else begin
				qcnt <= 16'h0000;
				step <= step + 2'h1;
				case (state)
					M_START: begin
						case (step)
							2'h0: begin
								bus.m_sda_oe <= 1'b0;
								bus.m_scl_oe <= 1'b0;
							end
							2'h1: bus.m_sda_oe <= 1'b1;
							default: begin
								bus.m_scl_oe <= 1'b1;
								state        <= M_BITS;
								step         <= 2'h0;
							end
						endcase
					end
					M_BITS: begin
						case (step)
							2'h0: bus.m_sda_oe <= ~tx[8];
							2'h1: bus.m_scl_oe <= 1'b0;
							2'h2: begin
								if (bitn == `MWIC_BITS_PER_BYTE) begin
									nack <= sda_s;
								end
							end
							default: begin
								bus.m_scl_oe <= 1'b1;
								tx           <= {tx[7:0], 1'b1};
								if (bitn == `MWIC_BITS_PER_BYTE) begin
									state     <= M_IDLE;
									req_ready <= 1'b1;
									done      <= 1'b1;
								end else begin
									bitn <= bitn + 4'h1;
								end
							end
						endcase
					end
					M_STOP: begin
						case (step)
							2'h0: bus.m_sda_oe <= 1'b1;
							2'h1: bus.m_scl_oe <= 1'b0;
							2'h2: bus.m_sda_oe <= 1'b0;
							default: begin
								state     <= M_IDLE;
								req_ready <= 1'b1;
								done      <= 1'b1;
							end
						endcase
					end
					default: begin
						state <= M_IDLE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			bus.m_scl_o <= 1'b0;
			bus.m_sda_o <= 1'b0;
		end else if (ce) begin
			bus.m_scl_o <= 1'b0;
			bus.m_sda_o <= 1'b0;
		end
	end

endmodule

// ===== hw/mwic_slave.sv
/*
 device end of the margin/watchdog command port: write-only serial slave,
 command decode, margining and watchdog settings, oscillator sync pin control.
 assumes bus wires, straps and the sync pin are asynchronous to ref_clk.
*/
`timescale 1ns/10ps
`include "mwic_params.svh"
module mwic_slave
	import mwic_pkg::*;
#(
	parameter logic [4:0] ADDR_HIGH = `MWIC_ADDR_HIGH_DEF,
	parameter int         OSC_HALF  = `MWIC_OSC_HALF_CYC
) (
	// clock, reset, enable
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	input  wire logic       ce,
	// serial bus
	mwic_if.dev             bus,
	// straps
	input  wire logic       clock_source_select_strap,
	input  wire logic       strap_bit_zero,
	// oscillator sync pin
	input  wire logic       oscillator_sync_pin_i,
	output logic            oscillator_sync_pin_o,
	output logic            oscillator_sync_pin_oe,
	output logic            switcher_clk,
	// margining settings
	output logic [3:0]      ldo_margin,
	output logic [3:0]      sw_margin,
	// watchdog settings
	output logic            wd_enable,
	output logic            wd_window,
	output logic [1:0]      wd_period,
	output logic            wd_kick
);

	// ==========================================================
	// input synchronisers: scl, sda, clock strap, address strap, sync pin
	logic [4:0]      sync_a;
	logic [4:0]      sync_b;
	logic [1:0]      prev_bus;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sync_a   <= 5'h1f;
			sync_b   <= 5'h1f;
			prev_bus <= 2'h3;
		end else if (ce) begin
			sync_a   <= {oscillator_sync_pin_i, strap_bit_zero,
				clock_source_select_strap, bus.sda, bus.scl};
			sync_b   <= sync_a;
			prev_bus <= sync_b[1:0];
		end
	end

	logic            scl_s;
	logic            sda_s;
	logic            strap_one_s;
	logic            strap_zero_s;
	logic            osc_in_s;
	logic            scl_rise;
	logic            scl_fall;
	logic            start_det;
	logic            stop_det;
	logic [6:0]      my_addr;

	assign scl_s        = sync_b[0];
	assign sda_s        = sync_b[1];
	assign strap_one_s  = sync_b[2];
	assign strap_zero_s = sync_b[3];
	assign osc_in_s     = sync_b[4];
	assign scl_rise     = scl_s & ~prev_bus[0];
	assign scl_fall     = ~scl_s & prev_bus[0];
	assign start_det    = scl_s & prev_bus[0] & prev_bus[1] & ~sda_s;
	assign stop_det     = scl_s & prev_bus[0] & ~prev_bus[1] & sda_s;
	// pull-ups make an open strap read high
	assign my_addr      = {ADDR_HIGH, strap_one_s, strap_zero_s};

	// ==========================================================
	// bus slave
	mwic_dev_state_t state;
	logic [3:0]      bit_cnt;
	logic [7:0]      shift;
	logic            byte_done;
	logic            sda_drive;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state     <= S_IDLE;
			bit_cnt   <= 4'h0;
			shift     <= 8'h00;
			byte_done <= 1'b0;
			sda_drive <= 1'b0;
		end else if (ce) begin
			byte_done <= 1'b0;
			if (stop_det) begin
				state     <= S_IDLE;
				sda_drive <= 1'b0;
			end else if (start_det) begin
				state     <= S_ADDR;
				bit_cnt   <= 4'h0;
				sda_drive <= 1'b0;
			end else begin
				case (state)
					S_ADDR, S_DATA: begin
						if (scl_rise) begin
							shift   <= {shift[6:0], sda_s};
							bit_cnt <= bit_cnt + 4'h1;
						end else if (scl_fall && bit_cnt == `MWIC_BITS_PER_BYTE) begin
							if (state == S_DATA) begin
								byte_done <= 1'b1;
								state     <= S_ACK;
								sda_drive <= 1'b1;
							end else if (shift[7:1] == my_addr
								&& shift[0] == `MWIC_RW_WRITE) begin
								state     <= S_ACK;
								sda_drive <= 1'b1;
							end else begin
								// read direction or other address: stay off the bus
								state <= S_IGNORE;
							end
						end
					end
					S_ACK: begin
						if (scl_fall) begin
							sda_drive <= 1'b0;
							bit_cnt   <= 4'h0;
							state     <= S_DATA;
						end
					end
					S_IDLE, S_IGNORE: begin
						state <= state;
					end
					default: begin
						state <= S_IDLE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			bus.s_sda_o  <= 1'b0;
			bus.s_sda_oe <= 1'b0;
		end else if (ce) begin
			bus.s_sda_o  <= 1'b0;
			bus.s_sda_oe <= sda_drive;
		end
	end

	// ==========================================================
	// command decode
	logic [2:0]      fld;
	logic [4:0]      val;
	logic            wd_ok;
	logic            is_first;

	assign fld      = shift[7:5];
	assign val      = shift[4:0];
	assign is_first = (val == `MWIC_VAL_NULL);
	assign wd_ok    = is_first || (val[4:3] == `MWIC_WD_MODE_ON);

	// armed operation; a transfer boundary disarms so a guard never leaks
	mwic_arm_t       arm;
	logic            marg_second;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			arm         <= ARM_NONE;
			marg_second <= 1'b0;
		end else if (ce) begin
			if (stop_det || start_det) begin
				arm         <= ARM_NONE;
				marg_second <= 1'b0;
			end else if (byte_done) begin
				if (arm == ARM_MARG && fld == `MWIC_FLD_MARG) begin
					// one more margining byte may follow for the other output
					arm         <= marg_second ? ARM_MARG : ARM_NONE;
					marg_second <= 1'b0;
				end else if (arm == ARM_WD && fld == `MWIC_FLD_WD) begin
					arm <= ARM_NONE;
				end else if (is_first && fld == `MWIC_FLD_MARG) begin
					arm         <= ARM_MARG;
					marg_second <= 1'b1;
				end else if (is_first && fld == `MWIC_FLD_WD) begin
					arm <= ARM_WD;
				end else begin
					arm <= ARM_NONE;
				end
			end
		end
	end

	// ==========================================================
	// settings
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ldo_margin <= `MWIC_MARG_NOMINAL;
			sw_margin  <= `MWIC_MARG_NOMINAL;
		end else if (ce && byte_done && arm == ARM_MARG
			&& fld == `MWIC_FLD_MARG && val[3:0] != `MWIC_MARG_BAD) begin
			if (val[4]) begin
				sw_margin <= val[3:0];
			end else begin
				ldo_margin <= val[3:0];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wd_enable <= 1'b0;
			wd_window <= 1'b0;
			wd_period <= `MWIC_WD_P1280;
			wd_kick   <= 1'b0;
		end else if (ce) begin
			wd_kick <= 1'b0;
			if (byte_done && arm == ARM_WD && fld == `MWIC_FLD_WD && wd_ok) begin
				if (is_first) begin
					// first command twice in a row: timer off
					wd_enable <= 1'b0;
				end else begin
					wd_enable <= 1'b1;
					wd_window <= val[`MWIC_WD_WIN_BIT];
					wd_period <= val[1:0];
					wd_kick   <= 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// oscillator sync pin; direction follows the strap live, not latched
	logic [7:0]      osc_cnt;
	logic            osc_tog;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			osc_cnt <= 8'h00;
			osc_tog <= 1'b0;
		end else if (ce) begin
			if (osc_cnt == 8'(OSC_HALF - 1)) begin
				osc_cnt <= 8'h00;
				osc_tog <= ~osc_tog;
			end else begin
				osc_cnt <= osc_cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			oscillator_sync_pin_o  <= 1'b0;
			oscillator_sync_pin_oe <= 1'b0;
			switcher_clk           <= 1'b0;
		end else if (ce) begin
			oscillator_sync_pin_o  <= osc_tog;
			oscillator_sync_pin_oe <= strap_one_s;
			switcher_clk           <= strap_one_s ? osc_tog : osc_in_s;
		end
	end

endmodule

// ===== shared/mwic_if.sv
/*
 two-wire serial bus between the host end and the device end.
 assumes both wires are open drain with pull-ups; the level is resolved here.
*/
`timescale 1ns/10ps
interface mwic_if;
	logic m_scl_o;
	logic m_scl_oe;
	logic m_sda_o;
	logic m_sda_oe;
	logic s_sda_o;
	logic s_sda_oe;
	logic scl;
	logic sda;

	// ==========================================================
	// wired-and with pull-up
	assign scl = ~(m_scl_oe & ~m_scl_o);
	assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

	modport dev (
		input  scl,
		input  sda,
		output s_sda_o,
		output s_sda_oe
	);

	modport host (
		input  scl,
		input  sda,
		output m_scl_o,
		output m_scl_oe,
		output m_sda_o,
		output m_sda_oe
	);
endinterface

// ===== shared/mwic_params.svh
/*
 constants of the margin/watchdog serial command port: address, command fields,
 value codes and timing counts. assumes it is included by its bare name.
*/
`ifndef MWIC_PARAMS_SVH
`define MWIC_PARAMS_SVH

// ==========================================================
// address
// upper five bits of the slave address, value is arbitrary
`define MWIC_ADDR_HIGH_DEF   5'h15
`define MWIC_RW_WRITE        1'b0

// ==========================================================
// command byte fields
`define MWIC_FLD_MARG        3'h1
`define MWIC_FLD_WD          3'h3
`define MWIC_VAL_NULL        5'h00
`define MWIC_MARG_BAD        4'hf
`define MWIC_MARG_NOMINAL    4'h0
`define MWIC_WD_MODE_ON      2'h1
`define MWIC_WD_WIN_BIT      2
`define MWIC_BITS_PER_BYTE   4'h8

// ==========================================================
// watchdog period codes and their times in ms
`define MWIC_WD_P1280        2'h0
`define MWIC_WD_P320         2'h1
`define MWIC_WD_P80          2'h2
`define MWIC_WD_P20          2'h3
`define MWIC_WD_P1280_MS     1280
`define MWIC_WD_P320_MS      320
`define MWIC_WD_P80_MS       80
`define MWIC_WD_P20_MS       20

// ==========================================================
// timing
`define MWIC_CLK_PERIOD_NS   10
`define MWIC_SCL_PERIOD_NS   10000
`define MWIC_SCL_QTR_CYC     ((`MWIC_SCL_PERIOD_NS / 4) / `MWIC_CLK_PERIOD_NS)
`define MWIC_OSC_HALF_CYC    8

`endif

// ===== shared/mwic_pkg.sv
/*
 types of the margin/watchdog serial command port.
 assumes mwic_params.svh is on the include path.
*/
package mwic_pkg;

	// ==========================================================
	// device end states
	typedef enum logic [4:0] {
		S_IDLE   = 5'h01,
		S_ADDR   = 5'h02,
		S_DATA   = 5'h04,
		S_ACK    = 5'h08,
		S_IGNORE = 5'h10
	} mwic_dev_state_t;

	// armed operation after a first command
	typedef enum logic [2:0] {
		ARM_NONE = 3'h1,
		ARM_MARG = 3'h2,
		ARM_WD   = 3'h4
	} mwic_arm_t;

	// ==========================================================
	// host end
	typedef enum logic [3:0] {
		M_IDLE  = 4'h1,
		M_START = 4'h2,
		M_BITS  = 4'h4,
		M_STOP  = 4'h8
	} mwic_host_state_t;

	typedef enum logic [1:0] {
		K_START = 2'h0,
		K_BYTE  = 2'h1,
		K_STOP  = 2'h2
	} mwic_req_kind_t;

endpackage

// ===== verification/margin_watchdog_i2c_cmd_bench.sv
/*
 bench joining host and device ends; drives host requests, checks settings.
 assumes the two ends meet on mwic_if; short QTR_CYC keeps the run brief.
*/
`timescale 1ns/10ps
`include "mwic_params.svh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_fail++; \
	$display("[ERR] %s exp %h got %h", nm, ex, got); end end
module margin_watchdog_i2c_cmd_bench;
	import mwic_pkg::*;
	// upper address bits, value is arbitrary
	localparam logic [4:0] AH = 5'h0b;
	localparam logic [6:0] AD = {AH, 2'h3};
	logic       ref_clk, rstn, strap1, strap0, ext_sync, req_valid, req_ready, done, nack;
	logic       sync_oe, sw_clk, wd_en, wd_win, kick, last_an, last_dn, ce, sync_o;
	logic [2:0] ext_d;
	logic [1:0] req_kind, wd_per;
	logic [7:0] req_byte;
	logic [3:0] ldo, sw;
	logic [6:0] taddr;
	int         n_fail = 0, n_tests = 0, kicks = 0;

	mwic_if bus_if ();
	mwic_slave #(.ADDR_HIGH(AH)) mwic_slave_i (.ref_clk(ref_clk), .rstn(rstn), .ce(ce),
		.bus(bus_if), .clock_source_select_strap(strap1), .strap_bit_zero(strap0),
		.oscillator_sync_pin_i(ext_sync), .oscillator_sync_pin_o(sync_o),
		.oscillator_sync_pin_oe(sync_oe), .switcher_clk(sw_clk), .ldo_margin(ldo),
		.sw_margin(sw), .wd_enable(wd_en), .wd_window(wd_win), .wd_period(wd_per),
		.wd_kick(kick));
	mwic_master #(.QTR_CYC(10)) mwic_master_i (.ref_clk(ref_clk), .rstn(rstn), .ce(ce),
		.bus(bus_if), .target_addr(taddr), .req_valid(req_valid), .req_kind(req_kind),
		.req_byte(req_byte), .req_ready(req_ready), .done(done), .nack(nack));
	mwic_properties mwic_properties_i (.ref_clk(ref_clk), .rstn(rstn),
		.m_scl_o(bus_if.m_scl_o), .m_scl_oe(bus_if.m_scl_oe), .m_sda_o(bus_if.m_sda_o),
		.m_sda_oe(bus_if.m_sda_oe), .s_sda_o(bus_if.s_sda_o), .s_sda_oe(bus_if.s_sda_oe),
		.scl(bus_if.scl), .sda(bus_if.sda));

	// ==========================================================
	// clocks; external sync clock is free running and unrelated in phase
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	initial begin
		ext_sync = 1'b0;
		#3;
		forever #80 ext_sync = ~ext_sync;
	end
	always @(posedge ref_clk) if (kick === 1'b1) kicks <= kicks + 1;
	// same three-stage delay as the device path (two synchroniser stages and the output register), so the selected clock lines up
	always @(posedge ref_clk) ext_d <= {ext_d[1:0], ext_sync};

	// ==========================================================
	// host requests
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic req(input logic [1:0] k, input logic [7:0] b);
		int i;
		@(posedge ref_clk);
		req_kind  <= k;
		req_byte  <= b;
		req_valid <= 1'b1;
		@(posedge ref_clk);
		req_valid <= 1'b0;
		for (i = 0; i < 2000; i++) begin
			#1;
			if (i == 0) `CHK("busy", 1'b0, req_ready)
			if (done === 1'b1) break;
			@(posedge ref_clk);
		end
		if (i == 2000) begin
			n_fail++;
			tally_and_finish();
		end
		`CHK("ready", 1'b1, req_ready)
	endtask

	task automatic xfer(input logic [6:0] a, input logic [31:0] bs, input int n);
		@(posedge ref_clk);
		taddr <= a;
		req(K_START, 8'h00);
		last_an = nack;
		last_dn = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			req(K_BYTE, bs[8*i +: 8]);
			last_dn |= nack;
		end
		req(K_STOP, 8'h00);
	endtask

	// ==========================================================
	// scenarios
	task automatic t_straps();
		int   tg;
		logic pv;
		for (int s = 0; s < 4; s++) begin
			@(posedge ref_clk);
			strap1 <= s[1];
			strap0 <= s[0];
			repeat (4) @(posedge ref_clk);
			#1;
			`CHK("sync_oe", s[1], sync_oe)
			tg = 0;
			pv = 1'b0;
			for (int j = 0; j <= 16; j++) begin
				@(posedge ref_clk);
				#1;
				`CHK("sw_clk", (s[1] ? sync_o : ext_d[2]), sw_clk)
				if (j > 0 && sw_clk !== pv) tg++;
				pv = sw_clk;
			end
			`CHK("sw_toggles", 16 / `MWIC_OSC_HALF_CYC, tg)
			xfer({AH, s[1:0]}, 32'h0, 0);
			`CHK("own_nack", 1'b0, last_an)
			xfer({AH, s[1:0]} ^ (s[0] ? 7'h01 : 7'h02), 32'h0, 0);
			`CHK("other_nack", 1'b1, last_an)
		end
	endtask

	// enable low must freeze the strap path; released again afterwards
	task automatic t_freeze();
		@(posedge ref_clk);
		ce     <= 1'b0;
		strap1 <= 1'b0;
		repeat (6) @(posedge ref_clk);
		#1;
		`CHK("frozen_oe", 1'b1, sync_oe)
		@(posedge ref_clk);
		ce <= 1'b1;
		repeat (4) @(posedge ref_clk);
		#1;
		`CHK("thawed_oe", 1'b0, sync_oe)
		@(posedge ref_clk);
		strap1 <= 1'b1;
		repeat (4) @(posedge ref_clk);
	endtask

	task automatic t_margin();
		xfer(AD, 32'h20253c, 3);
		`CHK("ldo", 4'h5, ldo)
		`CHK("sw", 4'hc, sw)
		`CHK("data_nack", 1'b0, last_dn)
		for (int c = 0; c < 15; c++) begin
			xfer(AD, {16'h0, 8'h20, 3'h1, 1'b1, c[3:0]}, 2);
			`CHK("sw_code", c[3:0], sw)
			`CHK("ldo_hold", 4'h5, ldo)
		end
		xfer(AD, 32'h203f, 2);
		`CHK("sw_bad", 4'he, sw)
	endtask

	task automatic t_guard();
		xfer(AD, 32'h27, 1);
		`CHK("unguarded", 4'h5, ldo)
		xfer(AD, 32'h20e523, 3);
		`CHK("undef_field", 4'h5, ldo)
		xfer(AD, 32'h20, 1);
		xfer(AD, 32'h23, 1);
		`CHK("stop_disarm", 4'h5, ldo)
		xfer(AD, 32'h206c, 2);
		`CHK("wrong_op", 1'b0, wd_en)
		xfer(AD, 32'h2023, 2);
		`CHK("ldo_set", 4'h3, ldo)
	endtask

	task automatic t_wd();
		int k;
		for (int v = 0; v < 8; v++) begin
			k = kicks;
			xfer(AD, {16'h0, 8'h60, 5'h0d, v[2:0]}, 2);
			`CHK("wd_en", 1'b1, wd_en)
			`CHK("wd_win", v[2], wd_win)
			`CHK("wd_per", v[1:0], wd_per)
			`CHK("wd_kick", k + 1, kicks)
		end
		xfer(AD, 32'h6070, 2);
		`CHK("wd_bad_on", 1'b1, wd_en)
		`CHK("wd_bad_per", 2'h3, wd_per)
		xfer(AD, 32'h6060, 2);
		`CHK("watchdog_disabled_code", 1'b0, wd_en)
		xfer(AD, 32'h6061, 2);
		`CHK("wd_bad", 1'b0, wd_en)
		`CHK("ldo_keep", 4'h3, ldo)
	endtask

	initial begin
		rstn      = 1'b0;
		req_valid = 1'b0;
		req_kind  = 2'h0;
		req_byte  = 8'h00;
		strap1    = 1'b1;
		strap0    = 1'b1;
		taddr     = AD;
		ce        = 1'b1;
		repeat (8) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge ref_clk);
		t_straps();
		t_freeze();
		t_margin();
		t_guard();
		t_wd();
		tally_and_finish();
	end
endmodule

// ===== verification/mwic_properties.sv
/*
 bus assertions between the host end and the device end.
 assumes QTR_CYC of 10 at the host end: one bit spans 40 ref_clk cycles.
*/
`timescale 1ns/10ps
module mwic_properties (
	// clock, reset
	input wire logic ref_clk,
	input wire logic rstn,
	// bus drivers and wires
	input wire logic m_scl_o,
	input wire logic m_scl_oe,
	input wire logic m_sda_o,
	input wire logic m_sda_oe,
	input wire logic s_sda_o,
	input wire logic s_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	// ==========================================================
	// bit counter; wires are sampled late, so edges are seen one cycle on
	logic       scl_q, sda_q, in_addr, acked;
	logic [3:0] bits;
	wire        scl_rise = scl & ~scl_q;
	wire        start_c  = scl & scl_q & sda_q & ~sda;
	wire        stop_c   = scl & scl_q & ~sda_q & sda;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			bits    <= 4'h0;
			in_addr <= 1'b0;
			acked   <= 1'b0;
		end else if (start_c) begin
			bits    <= 4'h0;
			in_addr <= 1'b1;
			acked   <= 1'b0;
		end else if (stop_c) begin
			acked <= 1'b0;
		end else if (scl_rise) begin
			bits <= (bits == 4'h9) ? 4'h1 : bits + 4'h1;
			if (bits == 4'h8 && in_addr) begin
				in_addr <= 1'b0;
				acked   <= ~sda;
			end
		end
	end

	// ==========================================================
	// properties
	sequence s_ack_up;
		$rose(s_sda_oe);
	endsequence
	sequence s_data_end;
		$fell(scl) && bits == 4'h8 && !in_addr && acked;
	endsequence

	a_rw_bit_write: assert property (scl_rise && in_addr && bits == 4'h7 |-> !sda)
		else $error("direction bit not write");
	a_ack_scl_low: assert property (s_ack_up |-> !scl)
		else $error("ack raised while clock high");
	a_ack_hold_bit: assert property (s_ack_up |-> s_sda_oe[*8])
		else $error("ack dropped early");
	a_ack_release: assert property (s_ack_up |-> ##[8:80] !s_sda_oe)
		else $error("ack not released");
	a_ack_ninth: assert property (s_sda_oe && scl_rise |-> bits == 4'h8)
		else $error("ack outside ninth bit");
	a_data_acked: assert property (s_data_end |-> ##[1:8] s_sda_oe)
		else $error("data byte not acked");
	a_data_ack_seen: assert property (scl_rise && bits == 4'h8 && !in_addr && acked |-> !sda)
		else $error("data ack not on wire");
	a_stop_quiet: assert property (stop_c |=> (!s_sda_oe)[*8])
		else $error("device drives after stop");
endmodule
